// ==== wlan_ap_tunnel_framer_timers.sv ====
// access point tunnel: stations, discovery timers, layer-2 framing
`timescale 1ns/100ps
module wlan_ap_tunnel_framer_timers
  import tunnel_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  // station elements from the parser
  input  wire logic         elem_valid,
  input  wire logic         elem_add,
  input  wire logic         elem_key,
  input  wire logic         elem_del,
  input  wire logic [7:0]   elem_radio,
  input  wire logic [47:0]  elem_mac,
  input  wire logic [7:0]   elem_policy,
  input  wire logic [127:0] elem_session_key,
  output logic              elem_done,
  output logic              elem_reject,
  // station lookup for the cipher path
  input  wire logic         lk_valid,
  input  wire logic [7:0]   lk_radio,
  input  wire logic [47:0]  lk_mac,
  output logic              lk_done,
  output logic              lk_hit,
  output cipher_t           lk_cipher,
  output logic [127:0]      lk_key,
  // discovery and keepalive events
  input  wire logic         disc_reply,
  input  wire logic         join_ok,
  input  wire logic         keepalive_reply,
  output logic              send_probe,
  output logic              send_join,
  output logic              send_keepalive,
  output logic              peer_dead,
  // transmit header build
  input  wire logic         tx_req,
  input  wire logic         tx_ctrl,
  input  wire logic         tx_probe,
  input  wire logic         tx_frag,
  input  wire logic         tx_more,
  output logic              hdr_valid,
  output logic [47:0]       hdr_dst,
  output logic [47:0]       hdr_src,
  output logic [15:0]       hdr_type,
  output logic [7:0]        hdr_flags,
  output logic [7:0]        hdr_frag_id,
  // receive classification
  input  wire logic         rx_valid,
  input  wire logic [15:0]  rx_type,
  input  wire logic [7:0]   rx_flags,
  output logic              rx_done,
  output logic              rx_tunnel,
  output logic              rx_control,
  output logic              rx_data,
  output logic              rx_fragment,
  output logic              rx_last
);
  logic              run;
  logic [5:0]        cipher_adv;
  logic [7:0]        max_probe_gap, probe_limit, probe_quiet_time;
  logic [7:0]        peer_timeout, keepalive_gap, join_delay;
  logic [47:0]       src_mac, peer_mac;
  logic              tick;
  disc_state_t       state;
  logic [7:0]        sec_cnt, dead_cnt, probe_cnt, frag_id;
  logic              first_probe;
  logic [STA_N-1:0]  sta_valid, add_hit, lk_vec;
  logic [7:0]        sta_radio [STA_N];
  logic [47:0]       sta_mac   [STA_N];
  cipher_t           sta_cipher [STA_N];
  logic [127:0]      sta_key   [STA_N];
  logic              wr, rd;
  logic [7:0]        ka_twice;
  cipher_t           pol;
  logic              pol_ok;
  logic [STA_W:0]    add_slot, free_slot, lk_slot;
  logic [STA_W-1:0]  put_slot;

  function automatic logic [7:0] clamp(input logic [31:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    if (v < {24'h0, lo})
      return lo;
    else if (v > {24'h0, hi})
      return hi;
    else
      return v[7:0];
  endfunction

  function automatic logic [STA_W:0] first_set(input logic [STA_N-1:0] v);
    logic [STA_W:0] r;
    r = '0;
    for (int i = STA_N - 1; i >= 0; i--)
      if (v[i])
        r = {1'b1, i[STA_W-1:0]};
    return r;
  endfunction

  // one-second enable for every interval counter
  tick_divider #(.CYCLES(TICK_CYCLES_P)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // apb: zero wait states, unmapped addresses answer with an error
  assign wr       = psel && penable && pwrite;
  assign rd       = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign ka_twice = {keepalive_gap[6:0], 1'b0};

  always_comb
  begin
    unique case (paddr)
      CTRL_ADDR, GAP_ADDR, LIMIT_ADDR, QUIET_ADDR, TOUT_ADDR, KA_ADDR,
      JOIN_ADDR, STATUS_ADDR, SRC_LO_ADDR, SRC_HI_ADDR, PEER_LO_ADDR,
      PEER_HI_ADDR, CIPHER_ADDR: pslverr = 1'b0;
      default:                   pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd)
    begin
      unique case (paddr)
        CTRL_ADDR:    prdata <= {31'h0, run};
        GAP_ADDR:     prdata <= {24'h0, max_probe_gap};
        LIMIT_ADDR:   prdata <= {24'h0, probe_limit};
        QUIET_ADDR:   prdata <= {24'h0, probe_quiet_time};
        TOUT_ADDR:    prdata <= {24'h0, peer_timeout};
        KA_ADDR:      prdata <= {24'h0, keepalive_gap};
        JOIN_ADDR:    prdata <= {24'h0, join_delay};
        STATUS_ADDR:  prdata <= {4'h0, sta_valid, frag_id, probe_cnt,
                                 5'h0, state};
        SRC_LO_ADDR:  prdata <= src_mac[31:0];
        SRC_HI_ADDR:  prdata <= {16'h0, src_mac[47:32]};
        PEER_LO_ADDR: prdata <= peer_mac[31:0];
        PEER_HI_ADDR: prdata <= {16'h0, peer_mac[47:32]};
        CIPHER_ADDR:  prdata <= {26'h0, cipher_adv};
        default:      prdata <= 32'h0;
      endcase
    end
  end

  // management settings; written intervals and counts are clamped, never wrapped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run              <= RUN_DEF;
      max_probe_gap    <= GAP_DEF;
      probe_limit      <= LIMIT_DEF;
      probe_quiet_time <= QUIET_DEF;
      peer_timeout     <= TOUT_DEF;
      keepalive_gap    <= KA_DEF;
      join_delay       <= JOIN_DEF;
      cipher_adv       <= CIPHER_DEF;
      src_mac          <= MAC_DEF;
      peer_mac         <= MAC_DEF;
    end
    else if (wr)
    begin
      unique case (paddr)
        CTRL_ADDR:    run <= pwdata[RUN_BIT];
        GAP_ADDR:     max_probe_gap <= clamp(pwdata, GAP_MIN, GAP_MAX);
        LIMIT_ADDR:   probe_limit <= clamp(pwdata, LIMIT_MIN, LIMIT_MAX);
        QUIET_ADDR:   probe_quiet_time <= clamp(pwdata, QUIET_MIN,
                                                QUIET_MAX);
        TOUT_ADDR:    peer_timeout <= clamp(pwdata, ka_twice,
                                            TOUT_MAX);
        KA_ADDR:
        begin
          keepalive_gap <= clamp(pwdata, KA_MIN, KA_MAX);
          // raising the keepalive gap drags the timeout up with it
          if ({1'b0, peer_timeout} <
              {clamp(pwdata, KA_MIN, KA_MAX), 1'b0})
            peer_timeout <= {clamp(pwdata, KA_MIN, KA_MAX)} << 1;
        end
        JOIN_ADDR:    join_delay <= clamp(pwdata, JOIN_MIN, JOIN_MAX);
        SRC_LO_ADDR:  src_mac[31:0] <= pwdata;
        SRC_HI_ADDR:  src_mac[47:32] <= pwdata[15:0];
        PEER_LO_ADDR: peer_mac[31:0] <= pwdata;
        PEER_HI_ADDR: peer_mac[47:32] <= pwdata[15:0];
        CIPHER_ADDR:  cipher_adv <= pwdata[5:0];
        default:      ;
      endcase
    end
  end

  // policy code decode and advertised-support check
  always_comb
  begin
    pol    = CIPH_BAD;
    pol_ok = 1'b0;
    if (elem_policy < 8'h06)
    begin
      pol    = cipher_t'(elem_policy[2:0]);
      pol_ok = cipher_adv[elem_policy[2:0]];
    end
  end

  genvar g;
  generate
    for (g = 0; g < STA_N; g++)
    begin : g_match
      assign add_hit[g] = sta_valid[g] && sta_radio[g] == elem_radio &&
                          sta_mac[g] == elem_mac;
      assign lk_vec[g]  = sta_valid[g] && sta_radio[g] == lk_radio &&
                          sta_mac[g] == lk_mac;
    end
  endgenerate

  // slot picks shared by the table writers and the lookup
  assign add_slot  = first_set(add_hit);
  assign free_slot = first_set(~sta_valid);
  assign lk_slot   = first_set(lk_vec);
  assign put_slot  = add_slot[STA_W] ? add_slot[STA_W-1:0]
                                     : free_slot[STA_W-1:0];

  // station table: add reuses a matching slot, else the lowest free one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sta_valid   <= '0;
      elem_done   <= 1'b0;
      elem_reject <= 1'b0;
    end
    else
    begin
      elem_done   <= elem_valid;
      elem_reject <= 1'b0;
      if (elem_valid && elem_del)
        sta_valid <= sta_valid & ~add_hit;
      else if (elem_valid && elem_key && !elem_add)
        elem_reject <= 1'b1;
      else if (elem_valid && elem_add)
      begin
        if ((elem_key && !pol_ok) || !(add_slot[STA_W] || free_slot[STA_W]))
          elem_reject <= 1'b1;
        else
        begin
          sta_valid[put_slot] <= 1'b1;
        end
      end
    end
  end

  // table payload has no reset; valid bits guard it
  always_ff @(posedge pclk)
  begin
    if (elem_valid && elem_add && !elem_del &&
        !(elem_key && !pol_ok) && (add_slot[STA_W] || free_slot[STA_W]))
    begin
      sta_radio[put_slot]  <= elem_radio;
      sta_mac[put_slot]    <= elem_mac;
      sta_cipher[put_slot] <= elem_key ? pol : CIPH_CLEAR;
      sta_key[put_slot]    <= elem_key ? elem_session_key : 128'h0;
    end
  end

  // lookup answers one cycle later with the station's key and cipher
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_done   <= 1'b0;
      lk_hit    <= 1'b0;
      lk_cipher <= CIPH_CLEAR;
      lk_key    <= 128'h0;
    end
    else
    begin
      lk_done <= lk_valid;
      if (lk_valid)
      begin
        lk_hit    <= lk_slot[STA_W];
        lk_cipher <= lk_slot[STA_W] ? sta_cipher[lk_slot[STA_W-1:0]]
                                    : CIPH_CLEAR;
        lk_key    <= lk_slot[STA_W] ? sta_key[lk_slot[STA_W-1:0]]
                                    : 128'h0;
      end
    end
  end

  // discovery, join and keepalive sequencing, all intervals counted in seconds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state          <= ST_IDLE;
      sec_cnt        <= 8'h0;
      dead_cnt       <= 8'h0;
      probe_cnt      <= 8'h0;
      first_probe    <= 1'b0;
      send_probe     <= 1'b0;
      send_join      <= 1'b0;
      send_keepalive <= 1'b0;
      peer_dead      <= 1'b0;
    end
    else
    begin
      send_probe     <= 1'b0;
      send_join      <= 1'b0;
      send_keepalive <= 1'b0;
      peer_dead      <= 1'b0;
      if (tick)
        sec_cnt <= sec_cnt + 8'h1;
      if (!run)
      begin
        state     <= ST_IDLE;
        probe_cnt <= 8'h0;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            state       <= ST_PROBE;
            first_probe <= 1'b1;
          end
          ST_PROBE:
          begin
            if (disc_reply)
            begin
              state   <= ST_JWAIT;
              sec_cnt <= 8'h0;
            end
            else if (first_probe ||
                     (tick && sec_cnt + 8'h1 >= max_probe_gap))
            begin
              first_probe <= 1'b0;
              sec_cnt     <= 8'h0;
              if (probe_cnt >= probe_limit)
                state <= ST_QUIET;
              else
              begin
                send_probe <= 1'b1;
                probe_cnt  <= probe_cnt + 8'h1;
              end
            end
          end
          ST_QUIET:
          begin
            if (disc_reply)
            begin
              state   <= ST_JWAIT;
              sec_cnt <= 8'h0;
            end
            // minimum waits take one more tick: the tick phase is free
            else if (tick && sec_cnt >= probe_quiet_time)
            begin
              state       <= ST_PROBE;
              probe_cnt   <= 8'h0;
              first_probe <= 1'b1;
            end
          end
          ST_JWAIT:
            if (tick && sec_cnt >= join_delay)
            begin
              state     <= ST_JOINING;
              send_join <= 1'b1;
              sec_cnt   <= 8'h0;
            end
          ST_JOINING:
            if (join_ok)
            begin
              state    <= ST_JOINED;
              sec_cnt  <= 8'h0;
              dead_cnt <= 8'h0;
            end
            else if (tick && sec_cnt + 8'h1 >= peer_timeout)
            begin
              state       <= ST_PROBE;
              probe_cnt   <= 8'h0;
              first_probe <= 1'b1;
            end
          ST_JOINED:
          begin
            if (tick && sec_cnt >= keepalive_gap)
            begin
              send_keepalive <= 1'b1;
              sec_cnt        <= 8'h0;
            end
            // a reply in the same cycle as the tick still restarts it
            if (keepalive_reply)
              dead_cnt <= 8'h0;
            else if (tick && dead_cnt >= peer_timeout)
            begin
              peer_dead   <= 1'b1;
              state       <= ST_PROBE;
              probe_cnt   <= 8'h0;
              first_probe <= 1'b1;
            end
            else if (tick)
              dead_cnt <= dead_cnt + 8'h1;
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // transmit header; a two-part set takes a fresh id on its first part
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hdr_valid   <= 1'b0;
      hdr_dst     <= 48'h0;
      hdr_src     <= 48'h0;
      hdr_type    <= 16'h0;
      hdr_flags   <= 8'h0;
      hdr_frag_id <= 8'h0;
      frag_id     <= 8'h0;
    end
    else
    begin
      hdr_valid <= tx_req;
      if (tx_req)
      begin
        hdr_src  <= src_mac;
        hdr_dst  <= tx_probe ? BCAST_MAC : peer_mac;
        hdr_type <= ETHERTYPE;
        hdr_flags        <= 8'h0;
        hdr_flags[C_POS] <= tx_ctrl;
        hdr_flags[F_POS] <= tx_frag;
        hdr_flags[L_POS] <= tx_frag && tx_more;
        if (tx_frag && tx_more)
        begin
          frag_id     <= frag_id + 8'h1;
          hdr_frag_id <= frag_id + 8'h1;
        end
        else
          hdr_frag_id <= tx_frag ? frag_id : 8'h0;
      end
    end
  end

  // receive steering by type and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_done     <= 1'b0;
      rx_tunnel   <= 1'b0;
      rx_control  <= 1'b0;
      rx_data     <= 1'b0;
      rx_fragment <= 1'b0;
      rx_last     <= 1'b0;
    end
    else
    begin
      rx_done <= rx_valid;
      if (rx_valid)
      begin
        rx_tunnel   <= rx_type == ETHERTYPE;
        rx_control  <= rx_type == ETHERTYPE && rx_flags[C_POS];
        rx_data     <= rx_type == ETHERTYPE && !rx_flags[C_POS];
        rx_fragment <= rx_type == ETHERTYPE && rx_flags[F_POS];
        rx_last     <= rx_type == ETHERTYPE && rx_flags[F_POS] &&
                       !rx_flags[L_POS];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gap_range_a: assert property (
    max_probe_gap >= GAP_MIN && max_probe_gap <= GAP_MAX)
    else $error("probe gap out of range");
  timeout_range_a: assert property (
    peer_timeout >= ka_twice && peer_timeout <= TOUT_MAX)
    else $error("peer timeout out of range");
  probe_cap_a: assert property (
    send_probe |-> probe_cnt <= probe_limit && probe_cnt != 8'h0)
    else $error("probe sent past the limit");
  ethertype_a: assert property (
    hdr_valid |-> hdr_type == ETHERTYPE && hdr_src == src_mac)
    else $error("bad ethertype or source");
  probe_bcast_a: assert property (
    tx_req && tx_probe |=> hdr_valid && hdr_dst == BCAST_MAC)
    else $error("probe not broadcast");
  ctrl_flag_a: assert property (
    tx_req |=> hdr_flags[C_POS] == $past(tx_ctrl))
    else $error("control flag wrong");
  frag_id_a: assert property (
    tx_req && tx_frag && tx_more |=> hdr_frag_id == $past(frag_id) + 8'h1)
    else $error("fragment_group_id not advanced");
  rx_class_a: assert property (
    rx_valid |=> rx_done && rx_tunnel == ($past(rx_type) == ETHERTYPE))
    else $error("rx classification wrong");
  station_del_a: assert property (
    elem_valid && elem_del |=> (sta_valid & $past(add_hit)) == '0)
    else $error("station not removed");
  lone_key_a: assert property (
    elem_valid && elem_key && !elem_add && !elem_del |=> elem_reject)
    else $error("lone key element accepted");

  probe_seen_c: cover property (send_probe ##[1:1000] send_join);
  joined_c: cover property (state == ST_JOINED && send_keepalive);
  dead_c: cover property (peer_dead);
  lookup_hit_c: cover property (lk_done && lk_hit);
endmodule

// ==== tunnel_pkg.sv ====
// shared constants and types for the access point tunnel block
package tunnel_pkg;
  // clock and one-second tick
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_SEC    = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;

  // station table size
  localparam int unsigned STA_N = 4;
  localparam int unsigned STA_W = 2;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] GAP_ADDR     = 8'h04;
  localparam logic [7:0] LIMIT_ADDR   = 8'h08;
  localparam logic [7:0] QUIET_ADDR   = 8'h0C;
  localparam logic [7:0] TOUT_ADDR    = 8'h10;
  localparam logic [7:0] KA_ADDR      = 8'h14;
  localparam logic [7:0] JOIN_ADDR    = 8'h18;
  localparam logic [7:0] STATUS_ADDR  = 8'h1C;
  localparam logic [7:0] SRC_LO_ADDR  = 8'h20;
  localparam logic [7:0] SRC_HI_ADDR  = 8'h24;
  localparam logic [7:0] PEER_LO_ADDR = 8'h28;
  localparam logic [7:0] PEER_HI_ADDR = 8'h2C;
  localparam logic [7:0] CIPHER_ADDR  = 8'h30;

  // control bits and reset values
  localparam int unsigned RUN_BIT    = 0;
  localparam logic        RUN_DEF    = 1'b0;
  localparam logic [5:0]  CIPHER_DEF = 6'h3F;
  localparam logic [47:0] MAC_DEF    = 48'h0000_0000_0000;

  // intervals in seconds, counts in requests
  localparam logic [7:0] GAP_DEF   = 8'h14;
  localparam logic [7:0] GAP_MIN   = 8'h02;
  localparam logic [7:0] GAP_MAX   = 8'hB4;
  localparam logic [7:0] LIMIT_DEF = 8'h0A;
  localparam logic [7:0] LIMIT_MIN = 8'h01;
  localparam logic [7:0] LIMIT_MAX = 8'hFF;
  localparam logic [7:0] QUIET_DEF = 8'h1E;
  localparam logic [7:0] QUIET_MIN = 8'h01;
  localparam logic [7:0] QUIET_MAX = 8'hFF;
  localparam logic [7:0] TOUT_DEF  = 8'h3C;
  localparam logic [7:0] TOUT_MAX  = 8'hF0;
  localparam logic [7:0] KA_DEF    = 8'h1E;
  localparam logic [7:0] KA_MIN    = 8'h01;
  localparam logic [7:0] KA_MAX    = 8'h78;
  localparam logic [7:0] JOIN_DEF  = 8'h05;
  localparam logic [7:0] JOIN_MIN  = 8'h01;
  localparam logic [7:0] JOIN_MAX  = 8'hFF;

  // layer-2 framing
  localparam logic [15:0] ETHERTYPE = 16'h88BB;
  localparam logic [47:0] BCAST_MAC = 48'hFFFF_FFFF_FFFF;
  localparam int unsigned C_POS = 7;
  localparam int unsigned F_POS = 6;
  localparam int unsigned L_POS = 5;

  typedef enum logic [2:0] {
    CIPH_WEP104 = 3'h0,
    CIPH_CLEAR  = 3'h1,
    CIPH_WEP40  = 3'h2,
    CIPH_WEP128 = 3'h3,
    CIPH_AES    = 3'h4,
    CIPH_TKIP   = 3'h5,
    CIPH_BAD    = 3'h7
  } cipher_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PROBE   = 3'h1,
    ST_QUIET   = 3'h2,
    ST_JWAIT   = 3'h3,
    ST_JOINING = 3'h4,
    ST_JOINED  = 3'h5
  } disc_state_t;
endpackage

// ==== tick_divider.sv ====
// one-cycle enable pulse once per second of pclk
`timescale 1ns/100ps
module tick_divider
  import tunnel_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // one-second enable
  output logic      tick
);
  logic [31:0] cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt >= CYCLES - 1)
    begin
      cnt  <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ==== ac_model.sv ====
// access controller model answering probes, joins and keepalives
`timescale 1ns/100ps
module ac_model
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // silence the controller, as when none is on the segment
  input  wire logic mute,
  // requests from the access point
  input  wire logic send_probe,
  input  wire logic send_join,
  input  wire logic send_keepalive,
  // answers
  output logic      disc_reply,
  output logic      join_ok,
  output logic      keepalive_reply
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {disc_reply, join_ok, keepalive_reply} <= 3'h0;
    else
    begin
      disc_reply      <= send_probe & !mute;
      join_ok         <= send_join & !mute;
      keepalive_reply <= send_keepalive & !mute;
    end
endmodule

// ==== tb_wlan_ap_tunnel_framer_timers.sv ====
// self-checking bench for the tunnel framer and timers
`timescale 1ns/100ps
module tb_wlan_ap_tunnel_framer_timers
  import tunnel_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, elem_valid = 1'b0, elem_add = 1'b0, mute = 1'b1;
  logic elem_key = 1'b0, elem_del = 1'b0, lk_valid = 1'b0, tx_req = 1'b0;
  logic tx_ctrl = 1'b0, tx_probe = 1'b0, tx_frag = 1'b0, tx_more = 1'b0;
  logic         rx_valid = 1'b0;
  logic [7:0]   paddr = 8'h00, radio = 8'h01, rx_flags = 8'h00, pol = 8'h00;
  logic [15:0]  rx_type = 16'h0000;
  logic [31:0]  pwdata = 32'h0;
  logic [47:0]  mac = 48'h0;
  logic [127:0] key = 128'h0;
  logic [47:0]  q[$];
  logic [7:0]   defs[6] = '{GAP_DEF, LIMIT_DEF, QUIET_DEF, TOUT_DEF, KA_DEF,
                            JOIN_DEF};
  int           seed = 32'hC9DD, n_errors = 0, checked = 0, i, n;
  wire pready, pslverr, elem_done, elem_reject, lk_done, lk_hit, send_probe;
  wire send_join, send_keepalive, disc_reply, join_ok, keepalive_reply;
  wire hdr_valid, rx_done, rx_tunnel, rx_control, rx_data, rx_fragment;
  wire          rx_last, peer_dead;
  wire [31:0]   prdata;
  wire cipher_t lk_cipher;
  wire [127:0]  lk_key;
  wire [47:0]   hdr_dst, hdr_src;
  wire [15:0]   hdr_type;
  wire [7:0]    hdr_flags, hdr_frag_id;

  // short tick so the second-based timers finish in a few hundred cycles
  wlan_ap_tunnel_framer_timers #(.TICK_CYCLES_P(10)) dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .elem_valid, .elem_add, .elem_key, .elem_del,
    .elem_radio(radio), .elem_mac(mac), .elem_policy(pol),
    .elem_session_key(key), .elem_done, .elem_reject, .lk_valid,
    .lk_radio(radio), .lk_mac(mac), .lk_done, .lk_hit, .lk_cipher, .lk_key,
    .disc_reply, .join_ok, .keepalive_reply, .send_probe, .send_join,
    .send_keepalive, .peer_dead, .tx_req, .tx_ctrl, .tx_probe, .tx_frag,
    .tx_more, .hdr_valid, .hdr_dst, .hdr_src, .hdr_type, .hdr_flags,
    .hdr_frag_id, .rx_valid, .rx_type, .rx_flags, .rx_done, .rx_tunnel,
    .rx_control, .rx_data, .rx_fragment, .rx_last
  );
  ac_model peer
  (
    .pclk, .presetn, .mute, .send_probe, .send_join, .send_keepalive,
    .disc_reply, .join_ok, .keepalive_reply
  );

  always #25 pclk = ~pclk;

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic test_done;
    if (q.size() != 0)
      n_errors++;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one transfer in flight at a time, so the oldest note is the match
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, q.pop_front());
    else if (elem_done)
      chk(elem_reject, q.pop_front());
    else if (lk_done)
      chk({lk_hit, lk_cipher, lk_key[15:0]}, q.pop_front());
    else if (hdr_valid)
      chk({hdr_src[7:0], hdr_dst[7:0], hdr_type, hdr_flags, hdr_frag_id},
          q.pop_front());
    else if (rx_done)
      chk({rx_tunnel, rx_control, rx_data, rx_fragment, rx_last},
          q.pop_front());
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      test_done();
    end
    else
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [47:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // w picks the strobe: element, lookup, transmit, receive
  task automatic go(input int w, input logic [47:0] e);
    q.push_back(e);
    {elem_valid, lk_valid, tx_req, rx_valid} <= 4'h8 >> w;
    @(posedge pclk);
    {elem_valid, lk_valid, tx_req, rx_valid} <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 6; i++)
      rd(GAP_ADDR + 8'(4 * i), {32'h0, defs[i]});
    apb(1'b1, GAP_ADDR, 32'hFF);
    rd(GAP_ADDR, {32'h0, GAP_MAX});
    apb(1'b1, GAP_ADDR, 32'h0);
    rd(GAP_ADDR, {32'h0, GAP_MIN});
    rd(8'h40, {1'b1, 32'h0});
    apb(1'b1, PEER_LO_ADDR, 32'h00C0FFEE);
    apb(1'b1, SRC_LO_ADDR, 32'h0000005A);
    mac <= 48'({$random(seed), $random(seed)});
    key <= {4{$random(seed)}};
    elem_key <= 1'b1;
    go(0, 40'h1);
    {elem_add, pol} <= {1'b1, 8'h06};
    go(0, 40'h1);
    for (i = 0; i < 6; i++)
    begin
      pol <= 8'(i);
      go(0, 40'h0);
      go(1, {1'b1, 3'(i), key[15:0]});
    end
    apb(1'b1, CIPHER_ADDR, 32'h0000000F);
    go(0, 40'h1);
    elem_del <= 1'b1;
    go(0, 40'h0);
    go(1, {1'b0, CIPH_CLEAR, 16'h0});
    for (i = 0; i < 16; i++)
    begin
      {tx_more, tx_frag, tx_probe, tx_ctrl} <= 4'(i);
      go(2, {8'h5A, i[1] ? 8'hFF : 8'hEE, ETHERTYPE, i[0], i[2],
             i[2] & i[3], 5'h0, (i[2] & i[3]) ? 8'(i - 11) : 8'h0});
    end
    for (i = 0; i < 16; i++)
    begin
      rx_type <= i[3] ? ETHERTYPE : 16'h0800;
      rx_flags <= {i[0], i[1], i[2], 5'h0};
      go(3, {i[3], i[3] & i[0], i[3] & !i[0], i[3] & i[1],
             i[3] & i[1] & !i[2]});
    end
    // silent controller: probes stop at the limit, then quiet
    apb(1'b1, LIMIT_ADDR, 32'h3);
    apb(1'b1, QUIET_ADDR, 32'h14);
    apb(1'b1, CTRL_ADDR, 32'h1);
    n = 0;
    repeat (200)
    begin
      @(posedge pclk);
      if (send_probe === 1'b1)
        n++;
    end
    chk(n, 3);
    mute <= 1'b0;
    n = 0;
    while (send_keepalive !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n == 2000, 0);
    // controller goes silent: dead only after the whole timeout
    mute <= 1'b1;
    n = 0;
    while (peer_dead !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n < 10 * TOUT_DEF || n == 2000, 0);
    test_done();
  end
endmodule
